//--- dv/clu_src_model.sv
// behavioural model of the peripheral sources feeding the logic unit
`timescale 1ns/1ps

module clu_src_model (
  input wire logic sys_clk,
  input clu_pkg::clu_src_t want,
  output clu_pkg::clu_src_t src
);
  import clu_pkg::*;

  // ----
  // source levels
  // ----
  // spi and serial levels are only offered as a master would make them
  // levels move just after an edge, like a real peripheral register
  always_ff @(posedge sys_clk)
  begin
    src <= want;
  end
endmodule : clu_src_model

//--- dv/configurable_lut_logic_test.sv
// self-checking bench of the two-LUT logic unit
`timescale 1ns/1ps

module configurable_lut_logic_test;
  import clu_pkg::*;

  logic sys_clk;
  logic rst;
  logic standbySleep;
  clu_axi_req_t axiReq;
  clu_axi_resp_t axiResp;
  clu_src_t want;
  clu_src_t src;
  logic [1:0] lutOutputPin;
  logic [1:0] lutOutputPinOe;
  int failCount;
  int samplesChecked;
  int cycles;
  int n;
  logic [31:0] d;
  logic [1:0] r;

  clu_top clu_top_inst (
    .sys_clk(sys_clk),
    .rst(rst),
    .axiReq(axiReq),
    .axiResp(axiResp),
    .srcIn(src),
    .standbySleep(standbySleep),
    .lutOutputPin(lutOutputPin),
    .lutOutputPinOe(lutOutputPinOe)
  );

  clu_src_model clu_src_model_inst (
    .sys_clk(sys_clk),
    .want(want),
    .src(src)
  );

  // ----
  // helpers
  // ----
  task automatic summarize();
    $display("checks %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      failCount++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
  endtask : tick

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] i, input logic [7:0] v);
    axiReq.awaddr <= {i, 2'h0};
    axiReq.awvalid <= 1'h1;
    axiReq.wdata <= {24'h0, v};
    axiReq.wstrb <= 4'hF;
    axiReq.wvalid <= 1'h1;
    axiReq.bready <= 1'h1;
    do
    begin
      @(posedge sys_clk);
      if (axiResp.awready) axiReq.awvalid <= 1'h0;
      if (axiResp.wready) axiReq.wvalid <= 1'h0;
    end while (axiResp.bvalid !== 1'h1);
    r = axiResp.bresp;
    axiReq.bready <= 1'h0;
    @(posedge sys_clk);
  endtask : wr

  task automatic rd(input logic [3:0] i);
    axiReq.araddr <= {i, 2'h0};
    axiReq.arvalid <= 1'h1;
    axiReq.rready <= 1'h1;
    do
    begin
      @(posedge sys_clk);
      if (axiResp.arready) axiReq.arvalid <= 1'h0;
    end while (axiResp.rvalid !== 1'h1);
    d = axiResp.rdata;
    r = axiResp.rresp;
    axiReq.rready <= 1'h0;
    @(posedge sys_clk);
  endtask : rd

  task automatic rdChk(input logic [3:0] i, input logic [7:0] e);
    rd(i);
    chk(d, {24'h0, e});
  endtask : rdChk

  // one source raised per input-1 selector code; lut 0 pins use [lut][input]
  function automatic clu_src_t srcFor(input logic [3:0] c);
    clu_src_t s;
    s = '0;
    case (c)
      4'h3: s.eventLine[0] = 1'h1;
      4'h4: s.eventLine[1] = 1'h1;
      4'h5: s.pinIn[0][1] = 1'h1;
      4'h6: s.comparatorOut[0] = 1'h1;
      4'h7: s.timerBWaveform[0] = 1'h1;
      4'h8: s.timerAWaveform[1] = 1'h1;
      4'h9: s.timerDWaveformB = 1'h1;
      4'hA: s.serialTx = 1'h1;
      4'hB: s.spiMosi = 1'h1;
      4'hC: s.comparatorOut[1] = 1'h1;
      4'hD: s.timerBWaveform[1] = 1'h1;
      4'hE: s.comparatorOut[2] = 1'h1;
      default: s = '0;
    endcase
    return s;
  endfunction : srcFor

  // ----
  // clock and watchdog
  // ----
  initial
  begin
    sys_clk = 1'h0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failCount++;
      summarize();
    end
  end

  // ----
  // scenarios
  // ----
  initial
  begin
    rst = 1'h1;
    standbySleep = 1'h0;
    axiReq = '0;
    want = '0;
    failCount = 0;
    samplesChecked = 0;
    cycles = 0;
    tick(20);
    rst <= 1'h0;
    tick(1);
    for (int k = 0; k < 6; k++)
    begin
      rdChk(k < 2 ? k[3:0] : k[3:0] + 4'h3, 8'h00);
    end
    rd(4'hE);
    chk(r, 2'h2);
    // parity table on the three pins, pin drive on
    wr(4'h6, 8'h55);
    wr(4'h7, 8'h05);
    wr(4'h8, 8'h96);
    wr(4'h5, 8'h09);
    wr(4'h0, 8'h01);
    for (int v = 0; v < 8; v++)
    begin
      want.pinIn[0] <= v[2:0];
      tick(8);
      chk(lutOutputPin[0], (8'h96 >> v) & 8'h01);
      chk(lutOutputPinOe[0], 1'h1);
    end
    wr(4'h8, 8'h00);
    rdChk(4'h8, 8'h96);
    // input 2 used as clock drops out of the index
    wr(4'h0, 8'h00);
    wr(4'h5, 8'h49);
    wr(4'h0, 8'h01);
    want.pinIn[0] <= 3'h4;
    tick(8);
    chk(lutOutputPin[0], 1'h0);
    // synchronizer and standby sleep
    wr(4'h0, 8'h00);
    wr(4'h5, 8'h19);
    wr(4'h0, 8'h01);
    want.pinIn[0] <= 3'h1;
    tick(10);
    chk(lutOutputPin[0], 1'h1);
    standbySleep <= 1'h1;
    tick(4);
    chk(lutOutputPin[0], 1'h0);
    standbySleep <= 1'h0;
    wr(4'h0, 8'h41);
    standbySleep <= 1'h1;
    tick(6);
    chk(lutOutputPin[0], 1'h1);
    standbySleep <= 1'h0;
    // rising-edge pulse lasts one peripheral cycle
    wr(4'h0, 8'h00);
    wr(4'h5, 8'h99);
    want.pinIn[0] <= 3'h0;
    wr(4'h0, 8'h01);
    tick(8);
    want.pinIn[0] <= 3'h1;
    n = 0;
    repeat (12)
    begin
      @(posedge sys_clk);
      if (lutOutputPin[0] === 1'h1) n++;
    end
    chk(n, 1);
    // unit and lut enables
    wr(4'h0, 8'h00);
    tick(4);
    chk(lutOutputPin[0], 1'h0);
    wr(4'h5, 8'h09);
    wr(4'h0, 8'h01);
    tick(8);
    chk(lutOutputPin[0], 1'h1);
    wr(4'h5, 8'h08);
    tick(6);
    chk(lutOutputPin[0], 1'h0);
    // input-1 source codes 0 and 3 to 14 with table selecting input 1 alone
    wr(4'h0, 8'h00);
    wr(4'h8, 8'h04);
    wr(4'h5, 8'h09);
    want <= '0;
    for (int c = 0; c < 15; c++)
    begin
      if (c != 1 && c != 2)
      begin
        wr(4'h0, 8'h00);
        wr(4'h6, {c[3:0], 4'h0});
        wr(4'h0, 8'h01);
        want <= srcFor(c[3:0]);
        tick(8);
        chk(lutOutputPin[0], c != 0);
        want <= '0;
        tick(8);
        chk(lutOutputPin[0], 1'h0);
      end
    end
    // sequencer: both LUTs high, D element then JK toggling
    wr(4'h0, 8'h00);
    wr(4'h8, 8'hFF);
    wr(4'hC, 8'hFF);
    wr(4'h9, 8'h01);
    wr(4'h1, 8'h01);
    wr(4'h0, 8'h01);
    tick(4);
    chk(lutOutputPin[0], 1'h1);
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h02);
    wr(4'h0, 8'h01);
    tick(4);
    d[0] = lutOutputPin[0];
    tick(1);
    chk(lutOutputPin[0] ^ d[0], 1'h1);
    chk(lutOutputPin[1], 1'h1);
    chk(lutOutputPinOe[1], 1'h0);
    wr(4'h5, 8'h08);
    rdChk(4'hD, 8'h02);
    summarize();
  end
endmodule : configurable_lut_logic_test

//--- verilog/clu_params.svh
// register indices, field positions, reset values and bus codes of the logic unit
//
// Overview of operation
// [RULE1] run_in_standby set keeps the peripheral clock enable running in standby sleep.
// [RULE2] run_in_standby clear: clock stops in standby; clocked LUT outputs go low.
// [RULE3] Idle sleep leaves truth-table decode and LUT outputs running normally.
// [RULE4] lut_clock_select high: input 2 edges clock filter, edge detector and sequencer.
// [RULE5] run_in_standby is ignored when a LUT needs no peripheral clock.
// [RULE6] unit_control bit 0 enables the whole unit.
// [RULE7] sequencer_function_select: 0 off, 1 DFF, 2 JK, 3 D latch, 4 RS latch.
// [RULE8] edge_detect_enable, bit 7, turns on the rising-edge pulse detector.
// [RULE9] lut_clock_select, bit 6: 0 peripheral clock, 1 input 2.
// [RULE10] Shared sequencer runs on the even LUT's selected clock.
// [RULE11] output_filter_select bits 5:4: 0 none, 1 synchronizer, 2 glitch filter.
// [RULE12] pin_output_enable, bit 3, drives the LUT output onto its pin.
// [RULE13] LUT enable is bit 0 of its clock/filter control register.
// [RULE14] input1_source_select bits 7:4 decode the fifteen listed sources.
// [RULE15] input0_source_select bits 3:0 decode like input 1 with its own variants.
// [RULE16] Software uses SPI-derived inputs only with the SPI port as master.
// [RULE17] Software uses serial-port inputs only in async or sync master operation.
// [RULE18] Control, sequencer and LUT control registers reset to zero.
// [RULE19] LUT output is truth-table bit indexed by inputs 2,1,0, input 2 high.
// [RULE20] With lut_clock_select high, input 2 indexes the table as low.
// [RULE21] Filters delay two to five clocks and clear after the LUT is disabled.
// [RULE22] Sequencer data/J/set from even LUT, gate/K/reset from odd; clears when even off.
// [RULE23] Protected registers change only while their unit or LUT is disabled.
// [RULE24] Masked and reserved selector codes present a constant low.
`ifndef CLU_PARAMS_SVH
`define CLU_PARAMS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define CLU_IDX_UNIT_CTRL 4'h0
`define CLU_IDX_SEQ_CTRL 4'h1
`define CLU_IDX_LUT0_UNIT_CONTROL 4'h5
`define CLU_IDX_LUT0_SEL_LOW 4'h6
`define CLU_IDX_LUT0_SEL_HIGH 4'h7
`define CLU_IDX_LUT0_TRUTH 4'h8
`define CLU_IDX_LUT1_UNIT_CONTROL 4'h9
`define CLU_IDX_LUT1_SEL_LOW 4'hA
`define CLU_IDX_LUT1_SEL_HIGH 4'hB
`define CLU_IDX_LUT1_TRUTH 4'hC
`define CLU_IDX_STATUS 4'hD

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define CLU_UNIT_EN_BIT 0
`define CLU_RUN_STBY_BIT 6
`define CLU_SEQ_SEL_MSB 3
`define CLU_INPUT0_SOURCE_SELECT_LSB 0
`define CLU_INPUT1_SOURCE_SELECT_LSB 4
`define CLU_INPUT2_SOURCE_SELECT_MSB 3
`define CLU_LUT_UNIT_CONTROL_MASK 8'hF9
`define CLU_REG_RESET 8'h00

// ----------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------
`define CLU_RESP_OKAY 2'h0
`define CLU_RESP_SLVERR 2'h2

`endif

//--- verilog/clu_pkg.sv
// types shared by the logic unit
package clu_pkg;

  typedef struct packed {
    logic [5:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [5:0] araddr;
    logic arvalid;
    logic rready;
  } clu_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } clu_axi_resp_t;

  // asynchronous sources; pinIn is [lut][input]
  typedef struct packed {
    logic [1:0] eventLine;
    logic [2:0] comparatorOut;
    logic [1:0] timerBWaveform;
    logic [2:0] timerAWaveform;
    logic timerDWaveformA;
    logic timerDWaveformB;
    logic serialTx;
    logic serialClk;
    logic spiMosi;
    logic spiSck;
    logic spiMiso;
    logic [1:0][2:0] pinIn;
  } clu_src_t;

  // layout matches the clock/filter control register
  typedef struct packed {
    logic edgeDetect;
    logic clkSel;
    logic [1:0] output_filter_select;
    logic pinOut;
    logic [1:0] unused;
    logic enable;
  } clu_lut_ctrl_t;

  typedef enum logic [1:0] {
    CLU_FILT_NONE = 2'h0,
    CLU_FILT_SYNC = 2'h1,
    CLU_FILT_GLITCH = 2'h2
  } clu_filt_e;

  typedef enum logic [3:0] {
    CLU_SEQ_OFF = 4'h0,
    CLU_SEQ_DFF = 4'h1,
    CLU_SEQ_JK = 4'h2,
    CLU_SEQ_LATCH = 4'h3,
    CLU_SEQ_RS = 4'h4
  } clu_seq_e;

  typedef struct packed {
    logic unitEnable;
    logic runInStandby;
    logic [3:0] sequencer_function_select;
    clu_lut_ctrl_t [1:0] lutCtrl;
    logic [1:0][7:0] selLow;
    logic [1:0][3:0] selHigh;
    logic [1:0][7:0] truth;
    clu_src_t srcMeta;
    clu_src_t srcSync;
    logic [1:0] in2Prev;
    logic [1:0][1:0] syncSh;
    logic [1:0][1:0] filtHist;
    logic [1:0] filtOut;
    logic [1:0] edgePrev;
    logic seqQ;
    logic [1:0] lutOut;
    logic [1:0] pinOe;
    logic awHeld;
    logic [3:0] awIdx;
    logic wHeld;
    logic [7:0] wData;
    logic wLane0;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [7:0] rData;
    logic [1:0] rResp;
  } clu_state_t;

endpackage : clu_pkg

//--- verilog/clu_top.sv
// two-LUT configurable logic unit with AXI4-Lite register slave
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "clu_params.svh"

module clu_top (
  input wire logic sys_clk,
  input wire logic rst,
  input clu_pkg::clu_axi_req_t axiReq,
  output clu_pkg::clu_axi_resp_t axiResp,
  input clu_pkg::clu_src_t srcIn,
  input wire logic standbySleep,
  output logic [1:0] lutOutputPin,
  output logic [1:0] lutOutputPinOe
);
  import clu_pkg::*;

  clu_state_t st;
  clu_state_t next_st;

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  function automatic logic srcPick(input logic [3:0] sel, input logic [1:0] idx,
                                   input logic lut, input clu_src_t s,
                                   input logic link, input logic fb);
    logic v;
    v = 1'b0;
    case (sel)
      4'h1: v = fb;
      4'h2: v = link;
      4'h3: v = s.eventLine[0];
      4'h4: v = s.eventLine[1];
      4'h5: v = s.pinIn[lut][idx];
      4'h6: v = s.comparatorOut[0];
      4'h7: v = s.timerBWaveform[0];
      4'h8: v = s.timerAWaveform[idx];
      4'h9: v = (idx == 2'h1) ? s.timerDWaveformB : s.timerDWaveformA;
      4'hA: v = (idx == 2'h0) ? s.serialClk : ((idx == 2'h1) ? s.serialTx : 1'b0);
      4'hB: v = (idx == 2'h0) ? s.spiSck : ((idx == 2'h1) ? s.spiMosi : s.spiMiso);
      4'hC: v = (idx != 2'h2) & s.comparatorOut[1];
      4'hD: v = (idx != 2'h2) & s.timerBWaveform[1];
      4'hE: v = (idx != 2'h2) & s.comparatorOut[2];
      default: v = 1'b0; // [RULE24]
    endcase
    return v;
  endfunction : srcPick

  // ----------------------------------------------------------------
  // per-LUT datapath
  // ----------------------------------------------------------------
  logic perEn;
  logic [1:0] in2Raw;
  logic [1:0][2:0] lutIdx;
  logic [1:0] lutRaw;
  logic [1:0] tick;
  logic [1:0] lutActive;
  logic [1:0] condOut;
  logic [1:0] edgeOut;
  logic [1:0] needsPer;
  logic [1:0] lutFinal;
  logic seqOn;

  // the peripheral clock is modelled as an enable that stops in standby unless run_in_standby is set
  assign perEn = st.unitEnable & ~(standbySleep & ~st.runInStandby); // [RULE1] [RULE2]
  assign seqOn = (st.sequencer_function_select != CLU_SEQ_OFF);

  genvar n;
  for (n = 0; n < 2; n++)
  begin : g_lut
    localparam int OTHER = 1 - n;
    logic in0;
    logic in1;
    // link reads the other LUT's registered output so that two linked LUTs
    // can never close a combinational loop
    assign in0 = srcPick(st.selLow[n][`CLU_INPUT0_SOURCE_SELECT_LSB +: 4], 2'h0, 1'(n), st.srcSync,
                         st.lutOut[OTHER], st.seqQ); // [RULE15]
    assign in1 = srcPick(st.selLow[n][`CLU_INPUT1_SOURCE_SELECT_LSB +: 4], 2'h1, 1'(n), st.srcSync,
                         st.lutOut[OTHER], st.seqQ); // [RULE14]
    assign in2Raw[n] = srcPick(st.selHigh[n], 2'h2, 1'(n), st.srcSync,
                               st.lutOut[OTHER], st.seqQ);
    assign lutIdx[n] = {in2Raw[n] & ~st.lutCtrl[n].clkSel, in1, in0}; // [RULE20]
    // decode is not gated by any sleep state
    assign lutRaw[n] = st.truth[n][lutIdx[n]]; // [RULE19] [RULE3]
    assign tick[n] = st.lutCtrl[n].clkSel ? (in2Raw[n] & ~st.in2Prev[n]) : perEn; // [RULE9] [RULE4]
    assign lutActive[n] = st.unitEnable & st.lutCtrl[n].enable; // [RULE6] [RULE13]
    always_comb
    begin
      case (st.lutCtrl[n].output_filter_select) // [RULE11]
        CLU_FILT_SYNC: condOut[n] = st.syncSh[n][1];
        CLU_FILT_GLITCH: condOut[n] = st.filtOut[n];
        default: condOut[n] = lutRaw[n];
      endcase
    end
    assign edgeOut[n] = st.lutCtrl[n].edgeDetect ? (condOut[n] & ~st.edgePrev[n])
                                                 : condOut[n]; // [RULE8]
    // only clocked stages on the peripheral clock care about standby
    assign needsPer[n] = ~st.lutCtrl[n].clkSel & ((st.lutCtrl[n].output_filter_select != 2'h0) |
                         st.lutCtrl[n].edgeDetect | ((n == 0) & seqOn)); // [RULE5]
    assign lutFinal[n] = lutActive[n] & ~(standbySleep & ~st.runInStandby & needsPer[n]) &
                         (((n == 0) & seqOn) ? st.seqQ : edgeOut[n]); // [RULE2]
  end

  // ----------------------------------------------------------------
  // register bus decode
  // ----------------------------------------------------------------
  logic [3:0] rdIdx;
  logic [7:0] rdValue;
  logic rdMapped;
  logic [1:0] protLut;
  logic protSeq;
  logic wrLut;

  assign rdIdx = axiReq.araddr[5:2];
  assign rdMapped = (rdIdx <= `CLU_IDX_STATUS);
  assign protLut = {2{st.unitEnable}} & {st.lutCtrl[1].enable, st.lutCtrl[0].enable}; // [RULE23]
  assign protSeq = protLut[0];
  // indices 5..8 belong to lut 0 and 9..C to lut 1; no single index bit splits them
  assign wrLut = (st.awIdx >= `CLU_IDX_LUT1_UNIT_CONTROL);

  always_comb
  begin
    case (rdIdx)
      `CLU_IDX_UNIT_CTRL: rdValue = 8'(({7'h00, st.runInStandby} << `CLU_RUN_STBY_BIT) |
                                       ({7'h00, st.unitEnable} << `CLU_UNIT_EN_BIT));
      `CLU_IDX_SEQ_CTRL: rdValue = {4'h0, st.sequencer_function_select};
      `CLU_IDX_LUT0_UNIT_CONTROL: rdValue = st.lutCtrl[0] & `CLU_LUT_UNIT_CONTROL_MASK;
      `CLU_IDX_LUT0_SEL_LOW: rdValue = st.selLow[0];
      `CLU_IDX_LUT0_SEL_HIGH: rdValue = {4'h0, st.selHigh[0]};
      `CLU_IDX_LUT0_TRUTH: rdValue = st.truth[0];
      `CLU_IDX_LUT1_UNIT_CONTROL: rdValue = st.lutCtrl[1] & `CLU_LUT_UNIT_CONTROL_MASK;
      `CLU_IDX_LUT1_SEL_LOW: rdValue = st.selLow[1];
      `CLU_IDX_LUT1_SEL_HIGH: rdValue = {4'h0, st.selHigh[1]};
      `CLU_IDX_LUT1_TRUTH: rdValue = st.truth[1];
      `CLU_IDX_STATUS: rdValue = {5'h00, st.seqQ, st.lutOut};
      default: rdValue = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic doWrite;
    logic [7:0] wd;
    doWrite = 1'b0;
    wd = 8'h00;
    next_st = st;
    next_st.srcMeta = srcIn;
    next_st.srcSync = st.srcMeta;
    next_st.in2Prev = in2Raw;

    // write channel: address and data in either order, answer after both
    if (axiReq.awvalid && !st.awHeld && !st.bValid)
    begin
      next_st.awHeld = 1'b1;
      next_st.awIdx = axiReq.awaddr[5:2];
    end
    if (axiReq.wvalid && !st.wHeld && !st.bValid)
    begin
      next_st.wHeld = 1'b1;
      next_st.wData = axiReq.wdata[7:0];
      next_st.wLane0 = axiReq.wstrb[0];
    end
    if (st.awHeld && st.wHeld)
    begin
      doWrite = st.wLane0;
      wd = st.wData;
      next_st.awHeld = 1'b0;
      next_st.wHeld = 1'b0;
      next_st.bValid = 1'b1;
      next_st.bResp = (st.awIdx <= `CLU_IDX_STATUS) ? `CLU_RESP_OKAY : `CLU_RESP_SLVERR;
    end
    if (st.bValid && axiReq.bready)
    begin
      next_st.bValid = 1'b0;
    end
    if (doWrite)
    begin
      case (st.awIdx)
        `CLU_IDX_UNIT_CTRL:
        begin
          next_st.unitEnable = wd[`CLU_UNIT_EN_BIT];
          next_st.runInStandby = wd[`CLU_RUN_STBY_BIT];
        end
        `CLU_IDX_SEQ_CTRL:
          if (!protSeq) next_st.sequencer_function_select = wd[`CLU_SEQ_SEL_MSB:0]; // [RULE23] [RULE7]
        `CLU_IDX_LUT0_UNIT_CONTROL, `CLU_IDX_LUT1_UNIT_CONTROL:
        begin
          // while enabled only the enable bit itself may change
          if (!protLut[wrLut]) next_st.lutCtrl[wrLut] = wd & `CLU_LUT_UNIT_CONTROL_MASK;
          else next_st.lutCtrl[wrLut].enable = wd[0]; // [RULE23] [RULE13]
        end
        `CLU_IDX_LUT0_SEL_LOW, `CLU_IDX_LUT1_SEL_LOW:
          if (!protLut[wrLut]) next_st.selLow[wrLut] = wd;
        `CLU_IDX_LUT0_SEL_HIGH, `CLU_IDX_LUT1_SEL_HIGH:
          if (!protLut[wrLut]) next_st.selHigh[wrLut] = wd[`CLU_INPUT2_SOURCE_SELECT_MSB:0];
        `CLU_IDX_LUT0_TRUTH, `CLU_IDX_LUT1_TRUTH:
          if (!protLut[wrLut]) next_st.truth[wrLut] = wd;
        // keeps the response already chosen above
        default: ;
      endcase
    end

    // read channel: one cycle from address to data
    if (axiReq.arvalid && !st.rValid)
    begin
      next_st.rValid = 1'b1;
      next_st.rData = rdValue;
      next_st.rResp = rdMapped ? `CLU_RESP_OKAY : `CLU_RESP_SLVERR;
    end
    else if (st.rValid && axiReq.rready)
    begin
      next_st.rValid = 1'b0;
    end

    // filter and edge stages advance on their own selected clock
    for (int i = 0; i < 2; i++)
    begin
      if (!lutActive[i])
      begin
        next_st.syncSh[i] = 2'h0; // [RULE21]
        next_st.filtHist[i] = 2'h0;
        next_st.filtOut[i] = 1'b0;
        next_st.edgePrev[i] = 1'b0;
      end
      else if (tick[i])
      begin
        next_st.syncSh[i] = {st.syncSh[i][0], lutRaw[i]}; // [RULE21] [RULE4]
        next_st.filtHist[i] = {st.filtHist[i][0], st.syncSh[i][1]};
        // a level must hold for three samples before the filter passes it
        if ((st.filtHist[i] == {2{st.syncSh[i][1]}}))
          next_st.filtOut[i] = st.syncSh[i][1];
        next_st.edgePrev[i] = condOut[i]; // [RULE8]
      end
      next_st.lutOut[i] = lutFinal[i];
      next_st.pinOe[i] = lutActive[i] & st.lutCtrl[i].pinOut; // [RULE12]
    end

    // shared sequencer, clocked by the even LUT only
    if (!lutActive[0])
      next_st.seqQ = 1'b0; // [RULE22]
    else if (tick[0]) // [RULE10]
    begin
      case (st.sequencer_function_select) // [RULE7] [RULE22]
        CLU_SEQ_DFF, CLU_SEQ_LATCH: if (edgeOut[1]) next_st.seqQ = edgeOut[0];
        CLU_SEQ_JK: next_st.seqQ = (edgeOut[0] & ~st.seqQ) | (~edgeOut[1] & st.seqQ);
        // both set and reset high is forbidden; it holds here
        CLU_SEQ_RS: if (edgeOut[0] != edgeOut[1]) next_st.seqQ = edgeOut[0];
        default: next_st.seqQ = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      st <= '0; // [RULE18]
    else
      st <= next_st;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign axiResp.awready = ~st.awHeld & ~st.bValid;
  assign axiResp.wready = ~st.wHeld & ~st.bValid;
  assign axiResp.bvalid = st.bValid;
  assign axiResp.bresp = st.bResp;
  assign axiResp.arready = ~st.rValid;
  assign axiResp.rvalid = st.rValid;
  assign axiResp.rdata = {24'h000000, st.rData};
  assign axiResp.rresp = st.rResp;
  assign lutOutputPin = st.lutOut;
  assign lutOutputPinOe = st.pinOe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_sync_run;
    (lutActive[0] && st.lutCtrl[0].output_filter_select == 2'h1 && !st.lutCtrl[0].clkSel && perEn)[*3];
  endsequence
  sequence s_jk_toggle;
    lutActive[0] && st.sequencer_function_select == 4'h2 && tick[0] && edgeOut[0] && edgeOut[1];
  endsequence

  property p_reset_clear;
    @(posedge sys_clk) disable iff (1'b0) rst |=> (st.unitEnable == 1'b0 && st.sequencer_function_select == 4'h0 &&
                                st.lutCtrl == '0 && st.selLow == '0);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("registers not zero after reset"); // [RULE18]
  property p_unit_off;
    !st.unitEnable |=> (lutOutputPin == 2'h0 && lutOutputPinOe == 2'h0);
  endproperty
  a_unit_off: assert property (p_unit_off) else $error("disabled unit drives its pins"); // [RULE6]
  property p_standby_low;
    (standbySleep && !st.runInStandby && needsPer[0]) |=> !st.lutOut[0];
  endproperty
  a_standby_low: assert property (p_standby_low) else $error("clocked output not low in standby"); // [RULE2]
  property p_standby_run;
    (standbySleep && st.runInStandby && lutActive[0] && !st.lutCtrl[0].clkSel)
      |=> st.syncSh[0][0] == $past(lutRaw[0]);
  endproperty
  a_standby_run: assert property (p_standby_run) else $error("clock stopped despite run in standby"); // [RULE1]
  property p_in2_masked;
    st.lutCtrl[0].clkSel |-> !lutIdx[0][2];
  endproperty
  a_in2_masked: assert property (p_in2_masked) else $error("input 2 indexes table while clocking"); // [RULE20]
  property p_truth_out;
    (lutActive[1] && st.lutCtrl[1] [5:4] == 2'h0 && !st.lutCtrl[1].edgeDetect)
      |=> st.lutOut[1] == $past(st.truth[1][lutIdx[1]]);
  endproperty
  a_truth_out: assert property (p_truth_out) else $error("output differs from truth table bit"); // [RULE19]
  property p_sync_delay;
    s_sync_run |-> condOut[0] == $past(lutRaw[0], 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("synchronizer delay not two clocks"); // [RULE21]
  property p_edge_single;
    (lutActive[0] && st.lutCtrl[0].edgeDetect && tick[0] && edgeOut[0]) ##1 lutActive[0]
      |-> !edgeOut[0];
  endproperty
  a_edge_single: assert property (p_edge_single) else $error("edge pulse longer than one clock"); // [RULE8]
  property p_seq_clear;
    !lutActive[0] |=> !st.seqQ;
  endproperty
  a_seq_clear: assert property (p_seq_clear) else $error("sequencer not cleared by even LUT off"); // [RULE22]
  property p_jk;
    s_jk_toggle |=> st.seqQ != $past(st.seqQ);
  endproperty
  a_jk: assert property (p_jk) else $error("JK element failed to toggle"); // [RULE7]
  property p_protect;
    protLut[0] |=> $stable(st.truth[0]) && $stable(st.selLow[0]);
  endproperty
  a_protect: assert property (p_protect) else $error("protected LUT register changed"); // [RULE23]
  property p_in2_clock;
    (lutActive[0] && st.lutCtrl[0].clkSel && !tick[0]) ##1 lutActive[0] |-> $stable(st.syncSh[0]);
  endproperty
  a_in2_clock: assert property (p_in2_clock) else $error("filter moved without input 2 edge"); // [RULE4]
  property p_pin_enable;
    (lutActive[0] && st.lutCtrl[0].pinOut) |=> lutOutputPinOe[0];
  endproperty
  a_pin_enable: assert property (p_pin_enable) else $error("pin not driven when enabled"); // [RULE12]

  // ----------------------------------------------------------------
  // decode, sequencer, filter, protection and pin-enable checks
  // ----------------------------------------------------------------
  property p_direct_out;
    (lutActive[0] && st.lutCtrl[0].output_filter_select == 2'h0 && !st.lutCtrl[0].edgeDetect && !seqOn)
      |=> st.lutOut[0] == $past(lutRaw[0]);
  endproperty
  a_direct_out: assert property (p_direct_out) else $error("unclocked output lost decode"); // [RULE3]
  property p_dff;
    (lutActive[0] && st.sequencer_function_select == 4'h1 && tick[0] && edgeOut[1]) |=> st.seqQ == $past(edgeOut[0]);
  endproperty
  a_dff: assert property (p_dff) else $error("D element did not take even output"); // [RULE7]
  property p_seq_to_pin;
    (lutActive[0] && seqOn && !standbySleep) |=> st.lutOut[0] == $past(st.seqQ);
  endproperty
  a_seq_to_pin: assert property (p_seq_to_pin) else $error("even output not sequencer"); // [RULE22]
  // filter and edge state must not survive a disable, or a re-enable glitches
  property p_filter_clear;
    !lutActive[0] |=> (st.syncSh[0] == 2'h0 && st.filtHist[0] == 2'h0 && !st.filtOut[0] &&
                       !st.edgePrev[0]);
  endproperty
  a_filter_clear: assert property (p_filter_clear) else $error("filter state kept"); // [RULE21]
  property p_seq_protect;
    protSeq |=> $stable(st.sequencer_function_select);
  endproperty
  a_seq_protect: assert property (p_seq_protect) else $error("protected select changed"); // [RULE23]
  property p_oe_off;
    !lutActive[0] |=> !lutOutputPinOe[0];
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("disabled LUT drives its pin"); // [RULE12]

endmodule : clu_top
